// *** hw/tx_command_buffer_events_map.vh ***
// Constants for the transmit command and buffer event register bank.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register window.
`ifndef TX_COMMAND_BUFFER_EVENTS_MAP_VH
`define TX_COMMAND_BUFFER_EVENTS_MAP_VH
// Register indices and byte addresses (byte = 4 * index)
`define IDX_IRQ_EN      12'h10A
`define IDX_EVENTS      12'h12C
`define IDX_LOST_CNT    12'h130
`define IDX_COLL_CNT    12'h132
`define IDX_CMD_RB      12'h108
`define IDX_CMD_WR      12'h144
`define IDX_BYTE_CNT    12'h146
`define ADDR_W          14
`define ADR_IRQ_EN      14'h0428
`define ADR_EVENTS      14'h04B0
`define ADR_LOST_CNT    14'h04C0
`define ADR_COLL_CNT    14'h04C8
`define ADR_CMD_RB      14'h0420
`define ADR_CMD_WR      14'h0510
`define ADR_BYTE_CNT    14'h0518
// Fixed identifier codes in bits 5..0
`define ID_IRQ_EN       6'h0B
`define ID_EVENTS       6'h0C
`define ID_LOST_CNT     6'h10
`define ID_COLL_CNT     6'h12
`define ID_CMD          6'h09
// Bit positions of enables and events; bits 12 and 13 are enables only
`define B_SW            6
`define B_DMA           7
`define B_RDY           8
`define B_UND           9
`define B_MISS          10
`define B_EARLY         11
`define B_COLL_HALF     12
`define B_LOST_HALF     13
`define B_DEST          15
// Command field positions
`define B_FORCE         8
`define B_ONECOLL       9
`define B_NOFCS         12
`define B_PADDIS        13
// Transmit numbers
`define THR_0           11'h005
`define THR_1           11'h17D
`define THR_2           11'h3FD
`define PAD_MIN         16'h003C
`define LEN_MIN         16'h0003
`define RETRY_MAX       5'h10
`define CNT_HALF        10'h1FF
`endif

// *** hw/tx_command_buffer_events.v ***
// Transmit command options, buffer interrupt enables, buffer events and
// the lost-frame and collision counters, behind an AXI4-Lite slave.
// Assumes all event inputs are one-cycle pulses from logic on sys_clk_i.
//
// Summary of operation
// - Threshold code picks 5, 381, 1021 or whole frame
// - Flush command drops queue, aborts frame bad CRC
// - One-collision flag abandons early, else 16 tries
// - CRC suppress flag omits frame check sequence
// - Padding on: short length padded to 60 bytes
// - Padding off: runts sent, CRC per suppress flag
// - Lengths below 3 bytes are refused
// - Bits 5..0 read fixed register identifier, except byte count
// - Software request raises interrupt once, sets flag
// - Each enable bit gates its own cause
// - DMA done sets flag, interrupts if enabled
// - Ready for transmit sets flag, interrupts if enabled
// - Underrun sets flag, abandons frame
// - Lost frame sets flag, bumps lost counter
// - First 128 bytes in set early flag
// - Address match flag yields to early flag
// - Reading events clears all event bits
// - Lost counter halfway step interrupts if enabled
// - Reading lost counter returns and zeroes it
// - Collision counter halfway step interrupts if enabled
// - Enables reset to identifier, config may load
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tx_command_buffer_events_map.vh"

module tx_command_buffer_events (
  // Clock and reset
  input  wire                sys_clk_i,
  input  wire                nrst_i,
  // AXI4-Lite write address and data
  input  wire [`ADDR_W-1:0]  s_axi_awaddr_i,
  input  wire                s_axi_awvalid_i,
  output wire                s_axi_awready_o,
  input  wire [31:0]         s_axi_wdata_i,
  input  wire [3:0]          s_axi_wstrb_i,
  input  wire                s_axi_wvalid_i,
  output wire                s_axi_wready_o,
  // AXI4-Lite write response
  output wire [1:0]          s_axi_bresp_o,
  output wire                s_axi_bvalid_o,
  input  wire                s_axi_bready_i,
  // AXI4-Lite read
  input  wire [`ADDR_W-1:0]  s_axi_araddr_i,
  input  wire                s_axi_arvalid_i,
  output wire                s_axi_arready_o,
  output wire [31:0]         s_axi_rdata_o,
  output wire [1:0]          s_axi_rresp_o,
  output wire                s_axi_rvalid_o,
  input  wire                s_axi_rready_i,
  // Configuration memory load
  input  wire                cfg_load_i,
  input  wire [15:0]         cfg_irq_en_i,
  // Events from the MAC and receive buffer
  input  wire                dma_done_i,
  input  wire                tx_ready_i,
  input  wire                underrun_i,
  input  wire                lost_frame_i,
  input  wire                early_bytes_i,
  input  wire                addr_match_i,
  input  wire                collision_i,
  input  wire                tx_done_i,
  // Transmit control to the MAC
  output wire                tx_go_o,
  output wire                tx_refused_o,
  output wire                tx_abandon_o,
  output wire                flush_o,
  output wire                abort_bad_fcs_o,
  output wire [1:0]          send_threshold_select_o,
  output wire [15:0]         start_bytes_o,
  output wire [15:0]         frame_len_o,
  output wire                append_fcs_o,
  output wire [4:0]          retry_limit_o,
  output wire                sending_o,
  // Host interrupt
  output wire                irq_o
);

  localparam SEL_NONE = 3'h0;
  localparam SEL_EN   = 3'h1;
  localparam SEL_EVT  = 3'h2;
  localparam SEL_LOST = 3'h3;
  localparam SEL_COLL = 3'h4;
  localparam SEL_CMDR = 3'h5;
  localparam SEL_CMDW = 3'h6;
  localparam SEL_LEN  = 3'h7;

  // Shared address decode for both bus directions
  function [2:0] reg_sel;
    input [`ADDR_W-1:0] a;
    begin
      case (a)
        `ADR_IRQ_EN:   reg_sel = SEL_EN;
        `ADR_EVENTS:   reg_sel = SEL_EVT;
        `ADR_LOST_CNT: reg_sel = SEL_LOST;
        `ADR_COLL_CNT: reg_sel = SEL_COLL;
        `ADR_CMD_RB:   reg_sel = SEL_CMDR;
        `ADR_CMD_WR:   reg_sel = SEL_CMDW;
        `ADR_BYTE_CNT: reg_sel = SEL_LEN;
        default:       reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  reg                awready_reg;
  reg                wready_reg;
  reg                aw_full_reg;
  reg                w_full_reg;
  reg [`ADDR_W-1:0]  awaddr_reg;
  reg [15:0]         wdata_reg;
  reg [1:0]          wstrb_reg;
  reg                bvalid_reg;
  reg [1:0]          bresp_reg;
  reg                arready_reg;
  reg                rvalid_reg;
  reg [31:0]         rdata_reg;
  reg [1:0]          rresp_reg;
  reg [15:6]         en_reg;
  reg [15:6]         evt_reg;
  reg [9:0]          lost_cnt_reg;
  reg [9:0]          coll_cnt_reg;
  reg                lost_half_reg;
  reg                coll_half_reg;
  reg [15:6]         cmd_reg;
  reg [15:0]         len_reg;
  reg                sending_reg;
  reg [4:0]          tries_reg;
  reg                go_reg;
  reg                refused_reg;
  reg                abandon_reg;
  reg                flush_reg;
  reg                abort_reg;
  reg [15:0]         start_reg;
  reg [15:0]         flen_reg;
  reg                irq_reg;
  reg                sw_req_reg;
  reg [4:0]          limit_reg;

  wire               aw_hs  = s_axi_awvalid_i & awready_reg;
  wire               w_hs   = s_axi_wvalid_i & wready_reg;
  wire               ar_hs  = s_axi_arvalid_i & arready_reg;
  wire               do_wr  = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire [2:0]         wsel   = reg_sel(awaddr_reg);
  wire [2:0]         rsel   = reg_sel(s_axi_araddr_i);
  wire [15:0]        wmask  = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire               wr_en  = do_wr & (wsel == SEL_EN);
  wire               wr_cmd = do_wr & (wsel == SEL_CMDW);
  wire               wr_len = do_wr & (wsel == SEL_LEN);
  wire               rd_evt  = ar_hs & (rsel == SEL_EVT);
  wire               rd_lost = ar_hs & (rsel == SEL_LOST);
  wire               rd_coll = ar_hs & (rsel == SEL_COLL);
  wire [15:0]        en_wr   = ({en_reg, 6'h00} & ~wmask) | (wdata_reg & wmask);
  wire [15:0]        cmd_wr  = ({cmd_reg, 6'h00} & ~wmask) | (wdata_reg & wmask);
  wire [15:0]        len_wr  = (len_reg & ~wmask) | (wdata_reg & wmask);
  wire               coll_cnt_evt = collision_i & sending_reg;

  // Write channels: address and data taken in either order
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      awaddr_reg  <= {`ADDR_W{1'b0}};
      wdata_reg   <= 16'h0000;
      wstrb_reg   <= 2'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
    end else begin
      if (aw_hs) begin
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
        awaddr_reg  <= s_axi_awaddr_i;
      end else if (do_wr) begin
        aw_full_reg <= 1'b0;
        awready_reg <= 1'b1;
      end
      if (w_hs) begin
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
        wdata_reg  <= s_axi_wdata_i[15:0];
        wstrb_reg  <= s_axi_wstrb_i[1:0];
      end else if (do_wr) begin
        w_full_reg <= 1'b0;
        wready_reg <= 1'b1;
      end
      // Read-only registers and holes answer with a decode error
      if (do_wr) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (wsel == SEL_EN || wsel == SEL_CMDW || wsel == SEL_LEN) ? 2'h0 : 2'h3;
      end else if (bvalid_reg & s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, data one cycle after address
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= 2'h0;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= (rsel == SEL_NONE || rsel == SEL_CMDW) ? 2'h3 : 2'h0;
      case (rsel)
        SEL_EN:   rdata_reg <= {16'h0000, en_reg[15:7], 1'b0, `ID_IRQ_EN};
        SEL_EVT:  rdata_reg <= {16'h0000, evt_reg, `ID_EVENTS};
        SEL_LOST: rdata_reg <= {16'h0000, lost_cnt_reg, `ID_LOST_CNT};
        SEL_COLL: rdata_reg <= {16'h0000, coll_cnt_reg, `ID_COLL_CNT};
        SEL_CMDR: rdata_reg <= {16'h0000, cmd_reg ^ 10'h040, `ID_CMD};
        SEL_LEN:  rdata_reg <= {16'h0000, len_reg};
        default:  rdata_reg <= 32'h00000000;
      endcase
    end else if (rvalid_reg & s_axi_rready_i) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Enables; a bus write does not store the request bit, and it always reads zero
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_reg     <= 10'h000;
      sw_req_reg <= 1'b0;
    end else begin
      sw_req_reg <= wr_en & en_wr[`B_SW];
      if (cfg_load_i) begin
        en_reg <= cfg_irq_en_i[15:6];
      end else if (wr_en) begin
        en_reg <= {en_wr[15:7], 1'b0};
      end
    end
  end

  // Sticky events; a set in the read cycle survives the clear
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evt_reg <= 10'h000;
    end else begin
      evt_reg[`B_SW]    <= sw_req_reg | (evt_reg[`B_SW] & ~rd_evt);
      evt_reg[`B_DMA]   <= dma_done_i | (evt_reg[`B_DMA] & ~rd_evt);
      evt_reg[`B_RDY]   <= tx_ready_i | (evt_reg[`B_RDY] & ~rd_evt);
      evt_reg[`B_UND]   <= underrun_i | (evt_reg[`B_UND] & ~rd_evt);
      evt_reg[`B_MISS]  <= lost_frame_i | (evt_reg[`B_MISS] & ~rd_evt);
      evt_reg[`B_EARLY] <= early_bytes_i | (evt_reg[`B_EARLY] & ~rd_evt);
      evt_reg[14:12]    <= 3'h0;
      // Early flag replaces address match as the frame grows
      evt_reg[`B_DEST]  <= addr_match_i | (evt_reg[`B_DEST] & ~rd_evt & ~early_bytes_i);
    end
  end

  // Lost-frame counter, wraps after all ones, cleared by its read
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lost_cnt_reg  <= 10'h000;
      lost_half_reg <= 1'b0;
    end else begin
      if (lost_frame_i) begin
        lost_cnt_reg <= rd_lost ? 10'h001 : lost_cnt_reg + 10'h001;
      end else if (rd_lost) begin
        lost_cnt_reg <= 10'h000;
      end
      // Halfway warning, held until the count is read
      if (lost_frame_i & ~rd_lost & (lost_cnt_reg == `CNT_HALF) & en_reg[`B_LOST_HALF]) begin
        lost_half_reg <= 1'b1;
      end else if (rd_lost) begin
        lost_half_reg <= 1'b0;
      end
    end
  end

  // Collision activity counter while sending, same halfway warning
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      coll_cnt_reg  <= 10'h000;
      coll_half_reg <= 1'b0;
    end else begin
      if (coll_cnt_evt) begin
        coll_cnt_reg <= rd_coll ? 10'h001 : coll_cnt_reg + 10'h001;
      end else if (rd_coll) begin
        coll_cnt_reg <= 10'h000;
      end
      if (coll_cnt_evt & ~rd_coll & (coll_cnt_reg == `CNT_HALF) & en_reg[`B_COLL_HALF]) begin
        coll_half_reg <= 1'b1;
      end else if (rd_coll) begin
        coll_half_reg <= 1'b0;
      end
    end
  end

  // Retry budget ends on the limit collision; underrun ends it too
  wire               abandon_now = sending_reg & (underrun_i |
                       (collision_i & ((tries_reg + 5'h01) >= limit_reg)));

  // Command latch, flush and abort of the frame on the wire
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_reg   <= 10'h040; // Frame check bit kept inverted
      limit_reg <= `RETRY_MAX;
      flush_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      if (wr_cmd) begin
        cmd_reg <= {2'h0, cmd_wr[`B_PADDIS], ~cmd_wr[`B_NOFCS], 2'h0, cmd_wr[`B_ONECOLL:6]};
        limit_reg <= cmd_wr[`B_ONECOLL] ? 5'h01 : `RETRY_MAX;
      end
      flush_reg <= wr_cmd & cmd_wr[`B_FORCE];
      // Abort within one cycle, well inside 64 bit times
      abort_reg <= wr_cmd & cmd_wr[`B_FORCE] & sending_reg;
    end
  end

  // Transmit request on a length write
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      len_reg     <= 16'h0000;
      go_reg      <= 1'b0;
      refused_reg <= 1'b0;
      start_reg   <= 16'h0000;
      flen_reg    <= 16'h0000;
    end else begin
      go_reg      <= wr_len & (len_wr >= `LEN_MIN);
      refused_reg <= wr_len & (len_wr < `LEN_MIN);
      if (wr_len) begin
        len_reg <= len_wr;
        if (!cmd_reg[`B_PADDIS] && len_wr < `PAD_MIN) begin
          flen_reg <= `PAD_MIN;
        end else begin
          flen_reg <= len_wr;
        end
        case (cmd_reg[7:6])
          2'h0:    start_reg <= {5'h00, `THR_0};
          2'h1:    start_reg <= {5'h00, `THR_1};
          2'h2:    start_reg <= {5'h00, `THR_2};
          default: start_reg <= len_wr;
        endcase
      end
    end
  end

  // Send state and collision tries of the current frame
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sending_reg <= 1'b0;
      tries_reg   <= 5'h00;
      abandon_reg <= 1'b0;
    end else begin
      abandon_reg <= abandon_now;
      if (go_reg) begin
        sending_reg <= 1'b1;
        tries_reg   <= 5'h00;
      end else if (abandon_now | tx_done_i | abort_reg) begin
        sending_reg <= 1'b0;
      end else if (sending_reg & collision_i) begin
        tries_reg <= tries_reg + 5'h01;
      end
    end
  end

  // Interrupt: enabled pending events, halfway warnings, software flag
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (|(evt_reg[15:7] & en_reg[15:7])) | evt_reg[`B_SW] |
                 lost_half_reg | coll_half_reg;
    end
  end

  assign s_axi_awready_o         = awready_reg;
  assign s_axi_wready_o          = wready_reg;
  assign s_axi_bresp_o           = bresp_reg;
  assign s_axi_bvalid_o          = bvalid_reg;
  assign s_axi_arready_o         = arready_reg;
  assign s_axi_rdata_o           = rdata_reg;
  assign s_axi_rresp_o           = rresp_reg;
  assign s_axi_rvalid_o          = rvalid_reg;
  assign tx_go_o                 = go_reg;
  assign tx_refused_o            = refused_reg;
  assign tx_abandon_o            = abandon_reg;
  assign flush_o                 = flush_reg;
  assign abort_bad_fcs_o         = abort_reg;
  assign send_threshold_select_o = cmd_reg[7:6];
  assign start_bytes_o           = start_reg;
  assign frame_len_o             = flen_reg;
  assign append_fcs_o            = cmd_reg[`B_NOFCS];
  assign retry_limit_o           = limit_reg;
  assign sending_o               = sending_reg;
  assign irq_o                   = irq_reg;

endmodule // tx_command_buffer_events

// *** verif/tx_command_buffer_events_props.sv ***
// Assertions for the transmit command and buffer event bank.
// Assumes it is bound to the bank and sees its ports only.
`timescale 1ns/1ps
`include "tx_command_buffer_events_map.vh"

module tx_command_buffer_events_props (
  // Clock, reset and read channel
  input logic               sys_clk_i, nrst_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o,
  input logic [`ADDR_W-1:0] s_axi_araddr_i,
  input logic [31:0]        s_axi_rdata_o,
  // Events and transmit control
  input logic               underrun_i, collision_i, tx_done_i, tx_go_o, tx_refused_o,
  input logic               tx_abandon_o, flush_o, abort_bad_fcs_o, sending_o,
  input logic [1:0]         send_threshold_select_o,
  input logic [15:0]        start_bytes_o, frame_len_o,
  input logic [4:0]         retry_limit_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [`ADDR_W-1:0] rd_addr_reg;

  // Address of the read in flight, so identifiers can be tied to it
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) rd_addr_reg <= '0;
    else if (s_axi_arvalid_i && s_axi_arready_o) rd_addr_reg <= s_axi_araddr_i;
  end

  // Transmit start and abort
  AST_START_BYTES: assert property (tx_go_o && send_threshold_select_o != 2'h3 |->
    start_bytes_o == (send_threshold_select_o == 2'h0 ? 16'h0005 :
                      send_threshold_select_o == 2'h1 ? 16'h017D : 16'h03FD)) else $error("start count wrong");
  AST_GO_MIN_LEN: assert property (tx_go_o |-> !tx_refused_o && frame_len_o >= 16'h0003)
    else $error("short frame started");
  AST_ABORT_FLUSH: assert property (abort_bad_fcs_o |-> flush_o ##1 !sending_o)
    else $error("abort without flush or stop");
  // Collision and underrun give-up
  AST_RETRY_LIMIT: assert property (retry_limit_o == 5'h01 || retry_limit_o == 5'h10)
    else $error("retry limit out of range");
  AST_ONE_COLL: assert property (collision_i && sending_o && !tx_done_i && retry_limit_o == 5'h01 |=> tx_abandon_o)
    else $error("single collision not abandoned");
  AST_UNDERRUN: assert property (underrun_i && sending_o && !tx_done_i |=> tx_abandon_o)
    else $error("underrun not abandoned");
  AST_ABANDON_STOP: assert property (tx_abandon_o |-> ##[0:1] !sending_o)
    else $error("sending after abandon");
  // Identifier bits of read data
  AST_ID_EVENTS: assert property (s_axi_rvalid_o && rd_addr_reg == `ADR_EVENTS |->
    s_axi_rdata_o[5:0] == `ID_EVENTS) else $error("event id wrong");
  AST_ID_LOST: assert property (s_axi_rvalid_o && rd_addr_reg == `ADR_LOST_CNT |->
    s_axi_rdata_o[5:0] == `ID_LOST_CNT) else $error("lost id wrong");

  // Main scenarios reached
  COV_GO: cover property (tx_go_o);
  COV_REFUSED: cover property (tx_refused_o);
  COV_ABORT: cover property (abort_bad_fcs_o);
  COV_ABANDON: cover property (tx_abandon_o);
endmodule // tx_command_buffer_events_props

bind tx_command_buffer_events tx_command_buffer_events_props u_props (
  .sys_clk_i, .nrst_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_araddr_i, .s_axi_rdata_o,
  .underrun_i, .collision_i, .tx_done_i, .tx_go_o, .tx_refused_o, .tx_abandon_o, .flush_o,
  .abort_bad_fcs_o, .sending_o, .send_threshold_select_o, .start_bytes_o, .frame_len_o, .retry_limit_o
);

// *** verif/axi_host_model.sv ***
// AXI4-Lite host master through which the bench reaches the bank.
// Assumes tb holds num_errors and end_of_test for a stuck bus.
`timescale 1ns/1ps
`include "tx_command_buffer_events_map.vh"

module axi_host_model (
  // Clock
  input  logic               sys_clk_i,
  // Write and read request channels
  output logic [`ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i,
  output logic [31:0]        s_axi_wdata_i,
  output logic [3:0]         s_axi_wstrb_i,
  output logic               s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i,
  // Answers
  input  logic               s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o,
  input  logic [1:0]         s_axi_bresp_o, s_axi_rresp_o,
  input  logic [31:0]        s_axi_rdata_o
);
  // Bus idle at time zero
  initial begin
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    s_axi_wstrb_i = 4'hF;
  end

  // Address and data offered together, each released once taken
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [15:0] d, output logic [1:0] resp);
    int n;
    @(posedge sys_clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= {16'h0000, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge sys_clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        s_axi_awvalid_i <= 1'b0;
        s_axi_awaddr_i  <= ~a; // Released lines must not keep the old value
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        s_axi_wvalid_i <= 1'b0;
        s_axi_wdata_i  <= ~{16'h0000, d};
      end
      if (s_axi_bvalid_o) break;
    end
    resp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    if (n == 64) tb.hang();
  endtask

  // Read with rready held until the answer is sampled
  task automatic rd(input logic [`ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge sys_clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge sys_clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arvalid_i <= 1'b0;
        s_axi_araddr_i  <= ~a;
      end
      if (s_axi_rvalid_o) break;
    end
    d = s_axi_rdata_o;
    resp = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    if (n == 64) tb.hang();
  endtask
endmodule // axi_host_model

// *** verif/tb.sv ***
// Self-checking bench for the transmit command and buffer event bank.
// Assumes the host model drives the bus and events are one-cycle pulses.
`timescale 1ns/1ps
`include "tx_command_buffer_events_map.vh"

module tb;
  logic               sys_clk_i = 1'b0;
  logic               nrst_i = 1'b0;
  logic [`ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0]        s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]         s_axi_wstrb_i;
  logic [1:0]         s_axi_bresp_o, s_axi_rresp_o, send_threshold_select_o;
  logic               s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic               s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic               tx_go_o, tx_refused_o, tx_abandon_o, flush_o, abort_bad_fcs_o, append_fcs_o, sending_o, irq_o;
  logic [15:0]        start_bytes_o, frame_len_o, sb, fl;
  logic [4:0]         retry_limit_o, rl;
  logic               cfg_load_i = 1'b0;
  logic [15:0]        cfg_irq_en_i = 16'h0000;
  logic [7:0]         ev = 8'h00;
  logic               af;
  int                 num_errors = 0, checked = 0, go_n = 0, ref_n = 0, ab_n = 0, abort_n = 0;
  wire dma_done_i = ev[0], tx_ready_i = ev[1], underrun_i = ev[2], lost_frame_i = ev[3];
  wire early_bytes_i = ev[4], addr_match_i = ev[5], collision_i = ev[6], tx_done_i = ev[7];

  tx_command_buffer_events DUT (.*);
  axi_host_model H (.*);

  // 10 MHz clock
  always #50 sys_clk_i = ~sys_clk_i;

  // Transmit control pulses captured where they stand
  always @(posedge sys_clk_i) begin
    if (tx_go_o) begin
      go_n++;
      {sb, fl, af, rl} = {start_bytes_o, frame_len_o, append_fcs_o, retry_limit_o};
    end
    if (tx_refused_o) ref_n++;
    if (tx_abandon_o) ab_n++;
    if (abort_bad_fcs_o && flush_o) abort_n++;
  end

  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [`ADDR_W-1:0] a, input logic [15:0] e, input logic [1:0] re);
    logic [31:0] d;
    logic [1:0]  r;
    H.rd(a, d, r);
    chk(d, {16'h0000, e});
    chk(r, re);
  endtask
  task automatic wrchk(input logic [`ADDR_W-1:0] a, input logic [15:0] d, input logic [1:0] re);
    logic [1:0] r;
    H.wr(a, d, r);
    chk(r, re);
  endtask
  task automatic pulse(input int i);
    @(posedge sys_clk_i);
    ev <= 8'h01 << i;
    @(posedge sys_clk_i);
    ev <= 8'h00;
  endtask
  task automatic wait2;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic irq_is(input logic e);
    wait2();
    chk(irq_o, e);
  endtask
  task automatic send(input logic [15:0] cmd, len);
    wrchk(`ADR_CMD_WR, cmd, 2'h0);
    wrchk(`ADR_BYTE_CNT, len, 2'h0);
    repeat (3) @(posedge sys_clk_i);
  endtask

  // Reset values, identifiers and refused accesses
  task automatic t_reset;
    rdchk(`ADR_IRQ_EN, 16'h000B, 2'h0);
    rdchk(`ADR_EVENTS, 16'h000C, 2'h0);
    rdchk(`ADR_LOST_CNT, 16'h0010, 2'h0);
    rdchk(`ADR_COLL_CNT, 16'h0012, 2'h0);
    rdchk(14'h0000, 16'h0000, 2'h3);
    wrchk(`ADR_CMD_RB, 16'hFFFF, 2'h3);
    rdchk(`ADR_CMD_RB, 16'h0009, 2'h0);
  endtask
  // Software request acts once; events read clears
  task automatic t_sw;
    wrchk(`ADR_IRQ_EN, 16'h0040, 2'h0);
    irq_is(1'b1);
    rdchk(`ADR_EVENTS, 16'h004C, 2'h0);
    irq_is(1'b0);
    rdchk(`ADR_IRQ_EN, 16'h000B, 2'h0);
  endtask
  // Each event with its enable, DMA done also without it; no receive DMA mode here
  task automatic t_events;
    int b[6] = '{7, 8, 9, 10, 11, 15};
    wrchk(`ADR_IRQ_EN, 16'hBF80, 2'h0);
    for (int i = 0; i < 6; i++) begin
      pulse(i);
      irq_is(1'b1);
      rdchk(`ADR_EVENTS, 16'h000C | (16'h0001 << b[i]), 2'h0);
    end
    rdchk(`ADR_LOST_CNT, 16'h0050, 2'h0);
    rdchk(`ADR_LOST_CNT, 16'h0010, 2'h0);
    pulse(5);
    pulse(4);
    rdchk(`ADR_EVENTS, 16'h080C, 2'h0);
    wrchk(`ADR_IRQ_EN, 16'h0000, 2'h0);
    pulse(0);
    irq_is(1'b0);
    rdchk(`ADR_EVENTS, 16'h008C, 2'h0);
  endtask
  // Lost counter half-range step and configuration load
  task automatic t_half;
    wrchk(`ADR_IRQ_EN, 16'h2000, 2'h0);
    repeat (511) pulse(3);
    irq_is(1'b0);
    pulse(3);
    irq_is(1'b1);
    rdchk(`ADR_LOST_CNT, 16'h8010, 2'h0);
    rdchk(`ADR_LOST_CNT, 16'h0010, 2'h0);
    rdchk(`ADR_EVENTS, 16'h040C, 2'h0);
    irq_is(1'b0);
    @(posedge sys_clk_i);
    {cfg_irq_en_i, cfg_load_i} <= {16'h0F80, 1'b1};
    @(posedge sys_clk_i);
    cfg_load_i <= 1'b0;
    rdchk(`ADR_IRQ_EN, 16'h0F8B, 2'h0);
    wrchk(`ADR_IRQ_EN, 16'h0000, 2'h0);
  endtask
  // Thresholds, padding, CRC and length floor
  task automatic t_tx;
    logic [15:0] thr[4] = '{16'h0005, 16'h017D, 16'h03FD, 16'h000A};
    int g;
    for (int i = 0; i < 4; i++) begin
      g = go_n;
      send(16'(i << 6), 16'h000A);
      chk(go_n, g + 1);
      chk(sb, thr[i]);
      chk(fl, 16'h003C);
      chk(af, 1'b1);
      pulse(7);
    end
    send(16'h3000, 16'h000A);
    chk(fl, 16'h000A);
    chk(af, 1'b0);
    rdchk(`ADR_CMD_RB, 16'h3009, 2'h0);
    pulse(7);
    g = ref_n;
    send(16'h0000, 16'h0002);
    chk(ref_n, g + 1);
    send(16'h0000, 16'h0003);
    chk(fl, 16'h003C);
    pulse(7);
  endtask
  // Collision limits, flush abort and underrun
  task automatic t_abort;
    int a = ab_n;
    int f = abort_n;
    send(16'h0200, 16'h0040);
    chk(rl, 5'h01);
    pulse(6);
    wait2();
    chk(ab_n, a + 1);
    send(16'h0000, 16'h0040);
    chk(rl, 5'h10);
    repeat (15) pulse(6);
    wait2();
    chk(ab_n, a + 1);
    pulse(6);
    wait2();
    chk(ab_n, a + 2);
    rdchk(`ADR_COLL_CNT, 16'h0452, 2'h0);
    send(16'h0000, 16'h0040);
    wrchk(`ADR_CMD_WR, 16'h0100, 2'h0);
    wait2();
    chk(abort_n, f + 1);
    chk(sending_o, 1'b0);
    send(16'h0000, 16'h0040);
    pulse(2);
    wait2();
    chk(ab_n, a + 3);
    rdchk(`ADR_EVENTS, 16'h020C, 2'h0);
  endtask

  task automatic hang;
    num_errors++;
    end_of_test();
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Reset for 12 cycles, then the scenarios
  initial begin
    repeat (12) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_sw();
    t_events();
    t_half();
    t_tx();
    t_abort();
    end_of_test();
  end
endmodule // tb
